// ### dv/occ_clock_switch_properties.sv
`timescale 1ns/1ps
module occ_clock_switch_properties (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // Register bus
  input wire occ_pkg::occ_wb_req_s  wbReq,
  input wire logic                  wbAck,
  input wire logic [31:0]           wbDatOut,
  // Fuses and device status
  input wire logic                  switchEnableFuse,
  input wire logic                  monitorDisableFuse,
  input wire logic [2:0]            initialSourceFuse,
  input wire logic                  wdtEnable,
  input wire logic                  sleepMode,
  input wire logic                  clockFailDetect,
  // Clock tree
  input wire occ_pkg::occ_osc_en_s  oscEn,
  input wire occ_pkg::occ_clk_cfg_s clkCfg,
  input wire logic                  failTrap
);
  logic [31:0] reqDat;
  logic        monOn;
  logic        divWr;
  logic        fbdWr;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Fuses only move inside reset, so their live value stands for the latched one
  assign monOn = !switchEnableFuse && !monitorDisableFuse;
  assign divWr = wbAck && wbReq.we && wbReq.adr == 8'h04;
  assign fbdWr = wbAck && wbReq.we && wbReq.adr == 8'h08 && wbReq.sel[1:0] == 2'h3;

  // Write data kept one cycle past the ack, since the decode may lag by one
  always_ff @(posedge clk)
  begin
    if (wbReq.cyc && wbReq.stb)
      reqDat <= wbReq.dat;
  end

  a_ack_timing: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("ack not a single pulse one cycle after request");
  a_fail_trap: assert property (
    monOn && clockFailDetect && !sleepMode |=> failTrap ##[0:1] clkCfg.sysSource inside {3'h0, 3'h1})
    else $error("clock failure not trapped or not moved to fast RC");
  a_trap_cause: assert property (
    failTrap |-> $past(monOn && clockFailDetect && !sleepMode))
    else $error("trap without an enabled, awake failure");
  a_low_power_rc_held: assert property ((wdtEnable || monOn && !sleepMode) |-> ##[1:2] oscEn.lowPowerRc)
    else $error("low-power RC dropped while needed");
  a_doze_ratio: assert property (divWr && wbReq.sel[1] |-> ##[0:1]
    clkCfg.cpuDivShift == (reqDat[11] ? reqDat[14:12] : 3'h0))
    else $error("cpu divider does not follow doze setting");
  a_rc_post: assert property (divWr && wbReq.sel[1] |-> ##[0:1]
    clkCfg.rcDivShift == (reqDat[10:8] == 3'h7 ? 4'h8 : {1'b0, reqDat[10:8]}))
    else $error("rc postscaler decode wrong");
  a_pll_post: assert property (divWr && wbReq.sel[0] |-> ##[0:1] clkCfg.pllPostDiv ==
    (reqDat[7:6] == 2'h3 ? 4'h8 : reqDat[7:6] == 2'h2 ? 4'h0 : 4'h2 << reqDat[6]))
    else $error("pll postscaler decode wrong");
  a_pll_pre: assert property (divWr && wbReq.sel[0] |-> ##[0:1]
    clkCfg.pllPreDiv == {1'b0, reqDat[4:0]} + 6'h02)
    else $error("pll prescaler decode wrong");
  a_pll_mult: assert property (fbdWr |-> ##[0:1]
    clkCfg.pllMult == {1'b0, reqDat[8:0]} + 10'h002)
    else $error("pll multiplier decode wrong");
  a_fuse_locked: assert property (
    wbAck && !wbReq.we && wbReq.adr == 8'h00 && switchEnableFuse |->
    wbDatOut[14:12] == initialSourceFuse && !wbDatOut[0])
    else $error("locked switch shows wrong source or request");

  c_trap: cover property (failTrap);
  c_div_write: cover property (divWr);
  c_locked_read: cover property (wbAck && !wbReq.we && switchEnableFuse);
endmodule

bind occ_clock_switch occ_clock_switch_properties i_props (
  .clk(clk), .nrst(nrst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
  .switchEnableFuse(switchEnableFuse), .monitorDisableFuse(monitorDisableFuse),
  .initialSourceFuse(initialSourceFuse), .wdtEnable(wdtEnable), .sleepMode(sleepMode),
  .clockFailDetect(clockFailDetect), .oscEn(oscEn), .clkCfg(clkCfg), .failTrap(failTrap)
);

// ### dv/occ_clock_switch_tb.sv
`timescale 1ns/1ps
module occ_clock_switch_tb;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  occ_pkg::occ_wb_req_s  wbReq = '0;
  logic                  wbAck;
  logic [31:0]           wbDatOut;
  logic                  switchEnableFuse = 1'b0;
  logic                  monitorDisableFuse = 1'b0;
  logic [2:0]            initialSourceFuse = 3'h0;
  logic [1:0]            primarySubmodeFuse = 2'h0;
  logic                  wdtEnable = 1'b0;
  logic                  sleepMode = 1'b0;
  logic                  irqEvent = 1'b0;
  logic                  oscStartupDone = 1'b0;
  logic                  pllLocked = 1'b0;
  logic                  newClkTick = 1'b0;
  logic                  clockFailDetect = 1'b0;
  occ_pkg::occ_osc_en_s  oscEn;
  occ_pkg::occ_clk_cfg_s clkCfg;
  logic                  failTrap;
  logic                  ioLock;
  int                    nFail = 0;
  int                    checked = 0;

  occ_clock_switch i_dut (
    .clk(clk), .nrst(nrst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .switchEnableFuse(switchEnableFuse), .monitorDisableFuse(monitorDisableFuse),
    .initialSourceFuse(initialSourceFuse), .primarySubmodeFuse(primarySubmodeFuse),
    .wdtEnable(wdtEnable), .sleepMode(sleepMode), .irqEvent(irqEvent),
    .oscStartupDone(oscStartupDone), .pllLocked(pllLocked), .newClkTick(newClkTick),
    .clockFailDetect(clockFailDetect), .oscEn(oscEn), .clkCfg(clkCfg), .ioLock(ioLock),
    .failTrap(failTrap)
  );

  // 40 MHz system clock
  initial forever #12.5 clk = ~clk;

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: request held until ack is sampled, released at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1)
    begin
      nFail++;
      closeOut();
    end
    q = wbDatOut;
    wbReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h00000000, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask

  task automatic unlock;
    wr(8'h10, 4'h3, 32'h00005A3C);
  endtask

  // Switch and source fuses change only while reset is held, where the block latches them
  task automatic resetDut(input logic swOff, input logic [2:0] src);
    @(posedge clk);
    nrst <= 1'b0;
    switchEnableFuse <= swOff;
    initialSourceFuse <= src;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      newClkTick <= 1'b1;
    end
    @(posedge clk);
    newClkTick <= 1'b0;
  endtask

  task automatic failPulse(input logic slp);
    @(posedge clk);
    clockFailDetect <= 1'b1;
    sleepMode <= slp;
    @(posedge clk);
    clockFailDetect <= 1'b0;
    sleepMode <= 1'b0;
  endtask

  task automatic testRegs;
    logic [31:0] v;
    rd(8'h04, 32'h00003040);
    rd(8'h08, 32'h00000030);
    rd(8'h0C, 32'h00000000);
    rd(8'h00, 32'h00000000);
    for (int i = 0; i < 8; i++)
    begin
      v = {16'h0000, 1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 1'b0, 5'(i * 4 + 3)};
      wr(8'h04, 4'h3, v);
      rd(8'h04, v);
    end
    wr(8'h08, 4'h3, 32'hFFFFFFFF);
    rd(8'h08, 32'h000001FF);
    wr(8'h0C, 4'h3, 32'hFFFFFFE0);
    rd(8'h0C, 32'h00000020);
    wr(8'h20, 4'h3, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000);
    wr(8'h00, 4'h3, 32'h00000401);
    rd(8'h00, 32'h00000000);
  endtask

  task automatic testDoze;
    wr(8'h04, 4'h3, 32'h0000D800);
    @(posedge clk) irqEvent <= 1'b1;
    @(posedge clk) irqEvent <= 1'b0;
    rd(8'h04, 32'h0000D000);
    wr(8'h04, 4'h3, 32'h00005800);
    @(posedge clk) irqEvent <= 1'b1;
    @(posedge clk) irqEvent <= 1'b0;
    rd(8'h04, 32'h00005800);
  endtask

  task automatic testFail;
    failPulse(1'b1);
    rd(8'h00, 32'h00000000);
    failPulse(1'b0);
    rd(8'h00, 32'h00000008);
    unlock();
    wr(8'h00, 4'h1, 32'h00000000);
    rd(8'h00, 32'h00000000);
    failPulse(1'b0);
  endtask

  // The one PLL target is reached from a plain RC mode, never from the other PLL mode
  task automatic testSwitch;
    unlock();
    wr(8'h00, 4'h2, 32'h00000600);
    wr(8'h00, 4'h2, 32'h00000400);
    unlock();
    wr(8'h00, 4'h1, 32'h00000009);
    rd(8'h00, 32'h00000601);
    tick(9);
    rd(8'h00, 32'h00000601);
    tick(1);
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h00006600);
    chk(32'(clkCfg.sysSource), 32'h00000006);
    chk(32'(oscEn), 32'h00000006);
    unlock();
    wr(8'h00, 4'h1, 32'h00000001);
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h00006600);
    // Crystal with PLL: the sequencer must wait for start-up and lock
    primarySubmodeFuse <= 2'h1;
    unlock();
    wr(8'h00, 4'h2, 32'h00000300);
    unlock();
    wr(8'h00, 4'h1, 32'h00000001);
    tick(12);
    rd(8'h00, 32'h00006301);
    oscStartupDone <= 1'b1;
    pllLocked <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h00006321);
    tick(10);
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h00003320);
    chk(32'(oscEn), 32'h00000015);
  endtask

  task automatic testLocked;
    resetDut(1'b1, 3'h2);
    unlock();
    wr(8'h00, 4'h3, 32'h00000441);
    rd(8'h00, 32'h00002240);
    chk(32'(oscEn.primary), 32'h00000001);
    chk(32'(ioLock), 32'h00000001);
    failPulse(1'b0);
    rd(8'h00, 32'h00002240);
  endtask

  // Main sequence
  initial
  begin
    resetDut(1'b0, 3'h0);
    testRegs();
    testDoze();
    testFail();
    testSwitch();
    testLocked();
    closeOut();
  end
endmodule

// ### src/occ_clock_switch.sv
`timescale 1ns/1ps
`include "occ_params.svh"

// Summary of operation
// - Secondary oscillator runs while enabled, or while it is the active clock.
// - Switch request bit starts a switch to the new source; zero means done.
// - With recover enabled, any interrupt clears doze enable, ratio back to 1:1.
// - Three-bit reduction field divides CPU clock by 1 up to 128 in powers of two.
// - Doze enable applies the reduction ratio; otherwise the ratio is one.
// - RC postscaler divides by 1,2,4..64, and code seven divides by 256.
// - PLL postscaler divides by 2, 4 or 8; code two is reserved.
// - PLL prescaler divides the reference by field value plus two.
// - PLL feedback multiplier is field value plus two, reset value gives 50.
// - RC trim is a signed six-bit step of 0.375 percent per code.
// - Switching and fail-safe monitor work only when the switch fuse is zero.
// - Switching disabled: new source ignored, current source shows the fuse choice.
// - Switching disabled: switch request bit held at zero, writes cannot set it.
// - Equal current and new sources: request cleared, switch abandoned.
// - Valid switch first clears PLL lock status and clock fail flag.
// - Start new oscillator; wait start-up timer for crystal, lock for PLL.
// - Count ten cycles of the new clock before moving the system clock.
// - On completion clear request bit and copy new source into current source.
// - Stop old source except low-power RC for watchdog/monitor or enabled secondary.
// - Monitor enabled keeps low-power RC running except in sleep.
// - On failure raise trap and fall back to internal RC, through PLL if used.
// - Clock fail flag reads one after a detected failure; software clears it.
// - Current and new source fields share one three-bit source encoding.
// - Lock status reads one when the PLL is requested and locked, zero otherwise.
module occ_clock_switch (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Wishbone slave
  input  wire occ_pkg::occ_wb_req_s  wbReq,
  output logic                       wbAck,
  output logic [31:0]                wbDatOut,
  // Configuration fuses; all but primarySubmodeFuse sampled while reset is held
  input  wire logic                  switchEnableFuse,
  input  wire logic                  monitorDisableFuse,
  input  wire logic [2:0]            initialSourceFuse,
  input  wire logic [1:0]            primarySubmodeFuse,
  // Surrounding device status
  input  wire logic                  wdtEnable,
  input  wire logic                  sleepMode,
  input  wire logic                  irqEvent,
  input  wire logic                  oscStartupDone,
  input  wire logic                  pllLocked,
  input  wire logic                  newClkTick,
  input  wire logic                  clockFailDetect,
  // Clock tree controls
  output occ_pkg::occ_osc_en_s       oscEn,
  output occ_pkg::occ_clk_cfg_s      clkCfg,
  output logic                       ioLock,
  output logic                       failTrap
);

  occ_pkg::occ_state_s s;
  occ_pkg::occ_state_s next_s;

  // PLL sources need a lock before switching over
  function automatic logic usesPll(input logic [2:0] src);
    usesPll = (src == occ_pkg::SRC_FAST_RC_PLL) || (src == occ_pkg::SRC_PRIMARY_PLL);
  endfunction

  // Crystal start-up only matters for the primary oscillator
  function automatic logic isPrimary(input logic [2:0] src);
    isPrimary = (src == occ_pkg::SRC_PRIMARY) || (src == occ_pkg::SRC_PRIMARY_PLL);
  endfunction

  // Every mode except the two primary modes, secondary and low-power RC derives from the fast RC
  function automatic logic isFastRc(input logic [2:0] src);
    isFastRc = (src == occ_pkg::SRC_FAST_RC) || (src == occ_pkg::SRC_FAST_RC_PLL) ||
               (src == occ_pkg::SRC_FAST_RC_DIV16) || (src == occ_pkg::SRC_FAST_RC_POST);
  endfunction

  // Helper signals of the next-state process
  logic       busHit;
  logic       busWrite;
  logic       canSwitch;
  logic       newReady;
  logic [2:0] tgtSrc;
  logic [2:0] actSrc;

  // Next-state logic: bus first, then hardware events so that hardware sets win
  always_comb
  begin
    next_s = s;
    next_s.wbAck = 1'b0;
    next_s.failTrap = 1'b0;
    // A strobe still held after ack is not a second access
    busHit = wbReq.cyc && wbReq.stb && !s.wbAck;
    busWrite = busHit && wbReq.we;
    // Clock lock only bites when the monitor is off
    canSwitch = s.switchAllowed && !(s.clkLock && !s.monitorAllowed);
    // Defaults keep the helpers free of latches
    newReady = 1'b0;
    tgtSrc = 3'h0;
    actSrc = 3'h0;

    // Single-cycle answer; unmapped addresses read zero and ignore writes
    if (busHit)
    begin
      next_s.wbAck = 1'b1;
      next_s.wbDat = 32'h0000_0000;
      if (wbReq.adr == `OCC_ADDR_OSC_CTRL)
      begin
        // Unused bit positions stay zero
        next_s.wbDat[`OCC_OSC_CUR_LSB +: 3] = s.currentSource;
        next_s.wbDat[`OCC_OSC_NEW_LSB +: 3] = s.newSourceSel;
        next_s.wbDat[`OCC_OSC_CLKLOCK_BIT] = s.clkLock;
        next_s.wbDat[`OCC_OSC_IOLOCK_BIT] = s.ioLock;
        next_s.wbDat[`OCC_OSC_PLLLOCK_BIT] = s.pllLockFlag;
        next_s.wbDat[`OCC_OSC_FAIL_BIT] = s.clockFailFlag;
        next_s.wbDat[`OCC_OSC_SECEN_BIT] = s.secondaryOscEnable;
        next_s.wbDat[`OCC_OSC_SWREQ_BIT] = s.switchRequest;
      end
      else if (wbReq.adr == `OCC_ADDR_CLK_DIV)
      begin
        // Fields in stored, undecoded form
        next_s.wbDat[`OCC_DIV_RECOVER_BIT] = s.recoverOnIrq;
        next_s.wbDat[`OCC_DIV_DOZE_LSB +: 3] = s.dozeRatio;
        next_s.wbDat[`OCC_DIV_DOZEEN_BIT] = s.dozeEnable;
        next_s.wbDat[`OCC_DIV_RCPOST_LSB +: 3] = s.rcPostscaler;
        next_s.wbDat[`OCC_DIV_PLL_POSTSCALER_LSB +: 2] = s.pllPostscaler;
        next_s.wbDat[`OCC_DIV_PLL_PRESCALER_LSB +: 5] = s.pllPrescaler;
      end
      else if (wbReq.adr == `OCC_ADDR_PLL_FBD)
      begin
        // Raw field; the plus-two offset lives in the decode
        next_s.wbDat[8:0] = s.pllMultiplier;
      end
      else if (wbReq.adr == `OCC_ADDR_RC_TUNING)
      begin
        // Trim code as written, sign bit included
        next_s.wbDat[5:0] = s.rcTrim;
      end
      else if (wbReq.adr == `OCC_ADDR_UNLOCK)
      begin
        // Lets software see whether its key landed
        next_s.wbDat[1:0] = {s.unlockHi, s.unlockLo};
      end
    end

    // Register writes
    if (busWrite)
    begin
      if (wbReq.adr == `OCC_ADDR_OSC_CTRL)
      begin
        // Each byte needs its own armed gate, consumed by the write
        if (wbReq.sel[1] && s.unlockHi)
        begin
          next_s.unlockHi = 1'b0;
          if (s.switchAllowed)
          begin
            next_s.newSourceSel = occ_pkg::occ_src_e'(wbReq.dat[`OCC_OSC_NEW_LSB +: 3]);
          end
        end
        if (wbReq.sel[0] && s.unlockLo)
        begin
          // Low byte: locks, secondary enable, fail clear, request
          next_s.unlockLo = 1'b0;
          next_s.clkLock = wbReq.dat[`OCC_OSC_CLKLOCK_BIT];
          next_s.ioLock = wbReq.dat[`OCC_OSC_IOLOCK_BIT];
          next_s.secondaryOscEnable = wbReq.dat[`OCC_OSC_SECEN_BIT];
          if (!wbReq.dat[`OCC_OSC_FAIL_BIT])
          begin
            next_s.clockFailFlag = 1'b0;
          end
          // Writing zero never aborts a switch in flight
          if (wbReq.dat[`OCC_OSC_SWREQ_BIT] && canSwitch && (s.swState == occ_pkg::SW_IDLE))
          begin
            next_s.switchRequest = 1'b1;
          end
        end
      end
      else if (wbReq.adr == `OCC_ADDR_CLK_DIV)
      begin
        if (wbReq.sel[1])
        begin
          // Upper byte: recovery, doze and RC postscaler
          next_s.recoverOnIrq = wbReq.dat[`OCC_DIV_RECOVER_BIT];
          next_s.dozeRatio = wbReq.dat[`OCC_DIV_DOZE_LSB +: 3];
          next_s.dozeEnable = wbReq.dat[`OCC_DIV_DOZEEN_BIT];
          next_s.rcPostscaler = wbReq.dat[`OCC_DIV_RCPOST_LSB +: 3];
        end
        if (wbReq.sel[0])
        begin
          // Reserved post code is stored as written
          next_s.pllPostscaler = wbReq.dat[`OCC_DIV_PLL_POSTSCALER_LSB +: 2];
          next_s.pllPrescaler = wbReq.dat[`OCC_DIV_PLL_PRESCALER_LSB +: 5];
        end
      end
      else if (wbReq.adr == `OCC_ADDR_PLL_FBD)
      begin
        if (wbReq.sel[1])
        begin
          // Only bit 8 lives in the upper byte
          next_s.pllMultiplier[8] = wbReq.dat[8];
        end
        if (wbReq.sel[0])
        begin
          next_s.pllMultiplier[7:0] = wbReq.dat[7:0];
        end
      end
      else if (wbReq.adr == `OCC_ADDR_RC_TUNING)
      begin
        if (wbReq.sel[0])
        begin
          // Upper byte holds nothing, so sel[1] is ignored
          next_s.rcTrim = wbReq.dat[5:0];
        end
      end
      else if (wbReq.adr == `OCC_ADDR_UNLOCK)
      begin
        // A wrong key disarms both gates
        next_s.unlockHi = (wbReq.dat[15:0] == `OCC_UNLOCK_KEY) && (wbReq.sel[1:0] == 2'h3);
        next_s.unlockLo = next_s.unlockHi;
      end
    end

    // Interrupt recovery beats a same-cycle software write of doze enable
    if (s.recoverOnIrq && irqEvent)
    begin
      next_s.dozeEnable = 1'b0;
    end

    // Lock status follows the PLL only while the PLL is requested
    next_s.pllLockFlag = pllLocked && s.oscEn.pll;

    // Switch sequencer
    case (s.swState)
      // Idle: a raised request is dropped or starts a wait
      occ_pkg::SW_IDLE:
      begin
        if (s.switchRequest)
        begin
          if (s.newSourceSel == s.currentSource)
          begin
            next_s.switchRequest = 1'b0;
          end
          else
          begin
            next_s.targetSource = s.newSourceSel;
            next_s.pllLockFlag = 1'b0;
            next_s.clockFailFlag = 1'b0;
            next_s.settleCnt = 4'h0;
            next_s.swState = occ_pkg::SW_WAIT;
          end
        end
      end
      // Wait: hold until the new oscillator is ready
      occ_pkg::SW_WAIT:
      begin
        // External clock mode has no crystal start-up to wait for
        newReady = (!isPrimary(s.targetSource) || (primarySubmodeFuse == 2'h0) ||
                    oscStartupDone) && (!usesPll(s.targetSource) || s.pllLockFlag);
        if (newReady)
        begin
          next_s.swState = occ_pkg::SW_COUNT;
        end
      end
      // Count ticks of the new clock, not of clk
      occ_pkg::SW_COUNT:
      begin
        if (newClkTick)
        begin
          if (s.settleCnt == (`OCC_SETTLE_CYCLES - 4'h1))
          begin
            next_s.swState = occ_pkg::SW_DONE;
          end
          else
          begin
            next_s.settleCnt = s.settleCnt + 4'h1;
          end
        end
      end
      // Hand over in one edge so no partial state shows
      occ_pkg::SW_DONE:
      begin
        next_s.currentSource = s.targetSource;
        next_s.switchRequest = 1'b0;
        next_s.swState = occ_pkg::SW_IDLE;
      end
      // No unused codes exist, but stay safe
      default:
      begin
        next_s.swState = occ_pkg::SW_IDLE;
      end
    endcase

    // Fail-safe fallback overrides any switch in flight
    if (s.monitorAllowed && clockFailDetect && !sleepMode)
    begin
      next_s.clockFailFlag = 1'b1;
      next_s.failTrap = 1'b1;
      next_s.currentSource = usesPll(s.currentSource) ? occ_pkg::SRC_FAST_RC_PLL
                                                      : occ_pkg::SRC_FAST_RC;
      // Software must request a new switch itself
      next_s.switchRequest = 1'b0;
      next_s.swState = occ_pkg::SW_IDLE;
    end

    // Synchronous reset; three fuses are caught here, so they may change later harmlessly
    if (!nrst)
    begin
      next_s = '0;
      // Fuse copies; of the fuse pins only primarySubmodeFuse is read after this
      next_s.switchAllowed = !switchEnableFuse;
      next_s.monitorAllowed = !switchEnableFuse && !monitorDisableFuse;
      next_s.currentSource = occ_pkg::occ_src_e'(initialSourceFuse);
      next_s.newSourceSel = occ_pkg::occ_src_e'(initialSourceFuse);
      next_s.targetSource = occ_pkg::occ_src_e'(initialSourceFuse);
      // Register fields back to power-on values
      next_s.dozeRatio = `OCC_DOZE_RST;
      next_s.rcPostscaler = `OCC_RCPOST_RST;
      next_s.pllPostscaler = `OCC_PLL_POSTSCALER_RST;
      next_s.pllPrescaler = `OCC_PLL_PRESCALER_RST;
      next_s.pllMultiplier = `OCC_PLL_MULTIPLIER_RST;
      next_s.rcTrim = `OCC_TRIM_RST;
      next_s.swState = occ_pkg::SW_IDLE;
    end

    // Oscillator requests: old source drops once current and target move on
    actSrc = next_s.currentSource;
    tgtSrc = (next_s.swState != occ_pkg::SW_IDLE) ? next_s.targetSource : actSrc;
    // Old and new source both run while a switch is in flight
    next_s.oscEn.primary = isPrimary(actSrc) || isPrimary(tgtSrc);
    next_s.oscEn.fastRc = isFastRc(actSrc) || isFastRc(tgtSrc);
    next_s.oscEn.pll = usesPll(actSrc) || usesPll(tgtSrc);
    // Secondary and low-power RC have reasons of their own to run
    next_s.oscEn.secondary = next_s.secondaryOscEnable ||
                             (actSrc == occ_pkg::SRC_SECONDARY) ||
                             (tgtSrc == occ_pkg::SRC_SECONDARY);
    next_s.oscEn.lowPowerRc = (actSrc == occ_pkg::SRC_LOW_POWER_RC) ||
                              (tgtSrc == occ_pkg::SRC_LOW_POWER_RC) || wdtEnable ||
                              (next_s.monitorAllowed && !sleepMode);

    // Decoded divider settings
    next_s.clkCfg.sysSource = actSrc;
    next_s.clkCfg.cpuDivShift = next_s.dozeEnable ? next_s.dozeRatio : 3'h0;
    next_s.clkCfg.rcDivShift = (next_s.rcPostscaler == 3'h7) ? 4'h8
                                                             : {1'b0, next_s.rcPostscaler};
    // Offsets added here so the tree needs no adder
    next_s.clkCfg.pllPreDiv = {1'b0, next_s.pllPrescaler} + 6'h02;
    next_s.clkCfg.pllMult = {1'b0, next_s.pllMultiplier} + 10'h002;
    // Trim passes through; the analog side applies the step
    next_s.clkCfg.rcTrim = next_s.rcTrim;
    // Reserved code gives zero so the tree can refuse it
    case (next_s.pllPostscaler)
      2'h0:    next_s.clkCfg.pllPostDiv = 4'h2;
      2'h1:    next_s.clkCfg.pllPostDiv = 4'h4;
      2'h3:    next_s.clkCfg.pllPostDiv = 4'h8;
      default: next_s.clkCfg.pllPostDiv = 4'h0;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  // Outputs straight from state flops
  assign wbAck = s.wbAck;
  assign wbDatOut = s.wbDat;
  assign oscEn = s.oscEn;
  assign clkCfg = s.clkCfg;
  assign ioLock = s.ioLock;
  assign failTrap = s.failTrap;

endmodule

// ### src/occ_params.svh
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

// Register byte addresses on the Wishbone bus
`define OCC_ADDR_OSC_CTRL   8'h00
`define OCC_ADDR_CLK_DIV    8'h04
`define OCC_ADDR_PLL_FBD    8'h08
`define OCC_ADDR_RC_TUNING  8'h0C
`define OCC_ADDR_UNLOCK     8'h10

// Oscillator control register field positions
`define OCC_OSC_CUR_LSB     12
`define OCC_OSC_NEW_LSB     8
`define OCC_OSC_CLKLOCK_BIT 7
`define OCC_OSC_IOLOCK_BIT  6
`define OCC_OSC_PLLLOCK_BIT 5
`define OCC_OSC_FAIL_BIT    3
`define OCC_OSC_SECEN_BIT   1
`define OCC_OSC_SWREQ_BIT   0

// Clock divisor register field positions
`define OCC_DIV_RECOVER_BIT 15
`define OCC_DIV_DOZE_LSB    12
`define OCC_DIV_DOZEEN_BIT  11
`define OCC_DIV_RCPOST_LSB  8
`define OCC_DIV_PLL_POSTSCALER_LSB 6
`define OCC_DIV_PLL_PRESCALER_LSB  0

// Reset values
`define OCC_DOZE_RST        3'h3
`define OCC_RCPOST_RST      3'h0
`define OCC_PLL_POSTSCALER_RST     2'h1
`define OCC_PLL_PRESCALER_RST      5'h00
`define OCC_PLL_MULTIPLIER_RST      9'h030
`define OCC_TRIM_RST        6'h00

// Unlock key, arbitrary value
`define OCC_UNLOCK_KEY      16'h5A3C

// Cycles of the new clock counted before the switch takes place
`define OCC_SETTLE_CYCLES   4'hA

`endif

// ### src/occ_pkg.sv
package occ_pkg;

  // Oscillator source encoding shared by current and new source fields
  typedef enum logic [2:0] {
    SRC_FAST_RC      = 3'h0,
    SRC_FAST_RC_PLL  = 3'h1,
    SRC_PRIMARY      = 3'h2,
    SRC_PRIMARY_PLL  = 3'h3,
    SRC_SECONDARY    = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_FAST_RC_DIV16 = 3'h6,
    SRC_FAST_RC_POST = 3'h7
  } occ_src_e;

  // Switch sequencer, Gray coded along the usual path
  typedef enum logic [1:0] {
    SW_IDLE  = 2'h0,
    SW_WAIT  = 2'h1,
    SW_COUNT = 2'h3,
    SW_DONE  = 2'h2
  } occ_sw_e;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } occ_wb_req_s;

  // Oscillator run requests
  typedef struct packed {
    logic primary;
    logic secondary;
    logic lowPowerRc;
    logic fastRc;
    logic pll;
  } occ_osc_en_s;

  // Decoded clock tree settings
  typedef struct packed {
    logic [2:0] sysSource;
    logic [2:0] cpuDivShift;
    logic [3:0] rcDivShift;
    logic [5:0] pllPreDiv;
    logic [3:0] pllPostDiv;
    logic [9:0] pllMult;
    logic [5:0] rcTrim;
  } occ_clk_cfg_s;

  // Complete block state
  typedef struct packed {
    occ_sw_e      swState;
    occ_src_e     currentSource;
    occ_src_e     newSourceSel;
    occ_src_e     targetSource;
    logic         switchRequest;
    logic         secondaryOscEnable;
    logic         clkLock;
    logic         ioLock;
    logic         pllLockFlag;
    logic         clockFailFlag;
    logic         recoverOnIrq;
    logic [2:0]   dozeRatio;
    logic         dozeEnable;
    logic [2:0]   rcPostscaler;
    logic [1:0]   pllPostscaler;
    logic [4:0]   pllPrescaler;
    logic [8:0]   pllMultiplier;
    logic [5:0]   rcTrim;
    logic         unlockHi;
    logic         unlockLo;
    logic [3:0]   settleCnt;
    logic         switchAllowed;
    logic         monitorAllowed;
    logic         wbAck;
    logic [31:0]  wbDat;
    logic         failTrap;
    occ_osc_en_s  oscEn;
    occ_clk_cfg_s clkCfg;
  } occ_state_s;

endpackage
